/* File: ccs_pkg.sv */
package ccs_pkg;
   localparam int unsigned CCS_ADDR_W = 4;
   localparam int unsigned CCS_DATA_W = 32;
   localparam int unsigned CCS_WORD_W = 16;
   localparam int unsigned CCS_MAG_W = 17;
   localparam int unsigned CCS_NCOEF = 9;
   // Word indices; byte address is four times the index
   localparam logic [3:0] CCS_IDX_BFLAGS = 4'h3;
   localparam logic [3:0] CCS_IDX_TFLAGS = 4'h4;
   localparam logic [3:0] CCS_IDX_BOFFS = 4'h5;
   localparam logic [3:0] CCS_IDX_BGAIN = 4'h6;
   localparam logic [3:0] CCS_IDX_TCG = 4'h7;
   localparam logic [3:0] CCS_IDX_TCO = 4'h8;
   localparam logic [3:0] CCS_IDX_SOTCO = 4'h9;
   localparam logic [3:0] CCS_IDX_SOTCG = 4'ha;
   localparam logic [3:0] CCS_IDX_SOBR = 4'hb;
   localparam logic [3:0] CCS_IDX_TOFFS = 4'hc;
   localparam logic [3:0] CCS_IDX_TGAIN = 4'hd;
   localparam logic [3:0] CCS_IDX_SOT = 4'he;
   localparam logic [3:0] CCS_IDX_TREF = 4'hf;
   // Bridge and temperature flag word fields; word reset value
   localparam int unsigned CCS_BF_CURVE = 14;
   localparam int unsigned CCS_BF_TREF_SIGN = 15;
   localparam int unsigned CCS_TF_USED_W = 6;
   localparam logic [15:0] CCS_RST_WORD = 16'h0000;
   // Coefficient order; flag pair index equals position for bridge flags, position minus 7 for temperature flags
   typedef enum logic [3:0] {
      CCS_C_BOFFS, CCS_C_BGAIN, CCS_C_TCG, CCS_C_TCO, CCS_C_SOTCO, CCS_C_SOTCG,
      CCS_C_SOBR, CCS_C_TGAIN, CCS_C_SOT
   } ccs_coef_t;
endpackage

/* File: ccs_coef_unit.sv */
`timescale 1ns/1ps
module ccs_coef_unit
   import ccs_pkg::*;
#(
   parameter int unsigned MAG_W = 17
)(
   input wire logic [MAG_W-2:0] low_word,
   input wire logic mag_msb,
   input wire logic sign_bit,
   output logic [MAG_W-1:0] magnitude,
   output logic negative,
   output logic [MAG_W:0] twos
);
   // RULE1: magnitude assembly
   assign magnitude = {mag_msb, low_word};
   // RULE2: sign bit meaning
   assign negative = sign_bit;
   // RULE16: two's complement form
   assign twos = sign_bit ? (~{1'b0, magnitude} + 1'b1) : {1'b0, magnitude};
endmodule // ccs_coef_unit

/* File: ccs_avmm_slave.sv */
`timescale 1ns/1ps
module ccs_avmm_slave
   import ccs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ccs_pkg::CCS_ADDR_W+1:0] address,
   input wire logic read,
   input wire logic write,
   output logic waitrequest,
   output logic acc_rd,
   output logic acc_wr,
   output logic [ccs_pkg::CCS_ADDR_W-1:0] acc_idx
);
   logic wait_q;
   // Waitrequest straight from a flop: high when idle, low in the second cycle of a request
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wait_q <= 1'b1;
      else
         wait_q <= ~((read | write) & wait_q);
   end
   assign waitrequest = wait_q;
   // Read data is fetched in the first cycle so it stands at the accepting edge
   assign acc_rd = read & wait_q;
   assign acc_wr = write & ~wait_q;
   assign acc_idx = address[ccs_pkg::CCS_ADDR_W+1:2];
endmodule // ccs_avmm_slave

/* File: ccs_store.sv */
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// RULE1: Each coefficient is a 17-bit magnitude, bit 16 from a flag word, bits 15:0 own word.
// RULE2: A sign flag of 0 means positive and 1 means negative.
// RULE3: Curve bit 14 of the bridge flags selects parabolic (0) or s-shaped (1) correction.
// RULE4: Bridge second-order coefficient uses flag bits 13:12 and word 0x0b.
// RULE5: Bridge flag bit 15 is the sign of the low-calibration temperature reference.
// RULE6: Temperature flags hold gain, second-order and offset pairs in bits 5:0, rest zero.
// RULE7: Temperature gain low bits live in 0x0d, second-order temperature in 0x0e.
// RULE8: The host writes only range codes 0x7000 down to 0x0000 into bridge offset word 0x05.
// RULE9: Bridge gain takes word 0x06 with flag bits 3:2.
// RULE10: Gain temperature coefficient takes word 0x07 with flag bits 5:4.
// RULE11: Offset temperature coefficient takes word 0x08 with flag bits 7:6.
// RULE12: Offset second-order term takes word 0x09 with flag bits 9:8.
// RULE13: Gain second-order term takes word 0x0a with flag bits 11:10.
// RULE14: The host writes only range codes into temperature offset word 0x0c.
// RULE15: Word 0x0f is the raw low-calibration temperature, signed by flag bit 15.
// RULE16: Each coefficient leaves as sign plus magnitude and as two's complement.
module ccs_store
   import ccs_pkg::*;
#(
   parameter int unsigned NCOEF = ccs_pkg::CCS_NCOEF
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ccs_pkg::CCS_ADDR_W+1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ccs_pkg::CCS_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [ccs_pkg::CCS_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [NCOEF*ccs_pkg::CCS_MAG_W-1:0] coef_magnitude,
   output logic [NCOEF-1:0] coef_negative,
   output logic [NCOEF*(ccs_pkg::CCS_MAG_W+1)-1:0] coef_twos,
   output logic curve_shape_select,
   output logic [ccs_pkg::CCS_WORD_W-1:0] low_cal_temp_reference,
   output logic low_cal_temp_sign
);
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_i_n = rst_s2_q;

   wire acc_rd;
   wire acc_wr;
   wire [CCS_ADDR_W-1:0] acc_idx;
   logic wait_raw;
   ccs_avmm_slave u_bus (
      .clk(ref_clk),
      .rst_n(rst_i_n),
      .address(avs_address),
      .read(avs_read),
      .write(avs_write),
      .waitrequest(wait_raw),
      .acc_rd(acc_rd),
      .acc_wr(acc_wr),
      .acc_idx(acc_idx)
   );
   assign avs_waitrequest = wait_raw;

   // Word store, indices 0x3 to 0xf; lower words 0x0 to 0x2 are never written and read zero
   logic [CCS_WORD_W-1:0] mem_q [16];
   function automatic logic mapped(input logic [3:0] idx);
      return idx >= CCS_IDX_BFLAGS;
   endfunction

   // Byte-lane merge on the low 16 bits
   wire [CCS_WORD_W-1:0] old_word = mem_q[acc_idx];
   wire [CCS_WORD_W-1:0] merged_word = {
      avs_byteenable[1] ? avs_writedata[15:8] : old_word[15:8],
      avs_byteenable[0] ? avs_writedata[7:0] : old_word[7:0]};
   // RULE6: unassigned temperature flag bits stay zero
   wire [CCS_WORD_W-1:0] tf_mask = {{(CCS_WORD_W-CCS_TF_USED_W){1'b0}},
                                    {CCS_TF_USED_W{1'b1}}};
   wire [CCS_WORD_W-1:0] store_word = (acc_idx == CCS_IDX_TFLAGS) ?
                                      (merged_word & tf_mask) : merged_word;
   wire do_store = acc_wr & mapped(acc_idx);

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_word
         always_ff @(posedge ref_clk or negedge rst_i_n)
         begin
            if (!rst_i_n)
               mem_q[gi] <= CCS_RST_WORD;
            else if (do_store && acc_idx == 4'(gi))
               mem_q[gi] <= store_word;
         end
      end
   endgenerate

   // Unmapped reads answer zero; upper 16 bits read zero
   wire [CCS_WORD_W-1:0] rd_word = mapped(acc_idx) ? old_word : CCS_RST_WORD;
   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
         avs_readdata <= '0;
      else if (acc_rd)
         avs_readdata <= {16'h0000, rd_word};
   end

   // Coefficient mapping: low-word index, flag word, bit position of the pair
   wire [CCS_WORD_W-1:0] bf = mem_q[CCS_IDX_BFLAGS];
   wire [CCS_WORD_W-1:0] tf = mem_q[CCS_IDX_TFLAGS];
   logic [CCS_WORD_W-1:0] lw [NCOEF];
   logic [NCOEF-1:0] mbit;
   logic [NCOEF-1:0] sbit;
   // RULE8: bridge offset taken as written, host keeps range codes
   assign lw[CCS_C_BOFFS] = mem_q[CCS_IDX_BOFFS];
   // RULE9: bridge gain
   assign lw[CCS_C_BGAIN] = mem_q[CCS_IDX_BGAIN];
   // RULE10: gain temperature coefficient
   assign lw[CCS_C_TCG] = mem_q[CCS_IDX_TCG];
   // RULE11: offset temperature coefficient
   assign lw[CCS_C_TCO] = mem_q[CCS_IDX_TCO];
   // RULE12: offset second order
   assign lw[CCS_C_SOTCO] = mem_q[CCS_IDX_SOTCO];
   // RULE13: gain second order
   assign lw[CCS_C_SOTCG] = mem_q[CCS_IDX_SOTCG];
   // RULE4: bridge second order
   assign lw[CCS_C_SOBR] = mem_q[CCS_IDX_SOBR];
   // RULE7: temperature gain and second order
   assign lw[CCS_C_TGAIN] = mem_q[CCS_IDX_TGAIN];
   assign lw[CCS_C_SOT] = mem_q[CCS_IDX_SOT];

   generate
      for (gi = 0; gi < 7; gi++)
      begin : g_bflag
         // RULE4: bridge flag pairs, magnitude msb then sign
         assign mbit[gi] = bf[2*gi];
         assign sbit[gi] = bf[2*gi+1];
      end
      for (gi = 0; gi < 2; gi++)
      begin : g_tflag
         // RULE6: temperature flag pairs
         assign mbit[7+gi] = tf[2*gi];
         assign sbit[7+gi] = tf[2*gi+1];
      end
   endgenerate

   logic [NCOEF*CCS_MAG_W-1:0] mag_d;
   logic [NCOEF-1:0] neg_d;
   logic [NCOEF*(CCS_MAG_W+1)-1:0] twos_d;
   generate
      for (gi = 0; gi < NCOEF; gi++)
      begin : g_unit
         ccs_coef_unit #(.MAG_W(CCS_MAG_W)) u_coef (
            .low_word(lw[gi]),
            .mag_msb(mbit[gi]),
            .sign_bit(sbit[gi]),
            .magnitude(mag_d[gi*CCS_MAG_W +: CCS_MAG_W]),
            .negative(neg_d[gi]),
            .twos(twos_d[gi*(CCS_MAG_W+1) +: CCS_MAG_W+1])
         );
      end
   endgenerate

   // Registered outputs; coefficients change one cycle after a write
   always_ff @(posedge ref_clk or negedge rst_i_n)
   begin
      if (!rst_i_n)
      begin
         coef_magnitude <= '0;
         coef_negative <= '0;
         coef_twos <= '0;
         curve_shape_select <= 1'b0;
         low_cal_temp_reference <= '0;
         low_cal_temp_sign <= 1'b0;
      end
      else
      begin
         // RULE16: coefficient presentation
         coef_magnitude <= mag_d;
         coef_negative <= neg_d;
         coef_twos <= twos_d;
         // RULE3: curve shape select
         curve_shape_select <= bf[CCS_BF_CURVE];
         // RULE15: raw low-calibration temperature
         low_cal_temp_reference <= mem_q[CCS_IDX_TREF];
         // RULE5: reference sign
         low_cal_temp_sign <= bf[CCS_BF_TREF_SIGN];
      end
   end
endmodule // ccs_store

/* File: ccs_store_asserts.sv */
`timescale 1ns/1ps
module ccs_store_asserts
   import ccs_pkg::*;
#(
   parameter int unsigned NCOEF = 9
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [CCS_ADDR_W+1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [CCS_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [CCS_DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NCOEF*CCS_MAG_W-1:0] coef_magnitude,
   input wire logic [NCOEF-1:0] coef_negative,
   input wire logic [NCOEF*(CCS_MAG_W+1)-1:0] coef_twos,
   input wire logic curve_shape_select,
   input wire logic low_cal_temp_sign
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Full-word writes only; partial lanes are not checked here, and the bench never drives them
   wire logic acc_w = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'b11;
   wire logic acc_r = avs_read && !avs_waitrequest;
   wire logic [3:0] ix = avs_address[5:2];
   a_curve_sel: assert property (acc_w && ix == CCS_IDX_BFLAGS |-> ##2
      curve_shape_select == $past(avs_writedata[14], 2)) else $error("curve select wrong");
   a_tref_sign: assert property (acc_w && ix == CCS_IDX_BFLAGS |-> ##2
      low_cal_temp_sign == $past(avs_writedata[15], 2)) else $error("reference sign wrong");
   a_sobr_flags: assert property (acc_w && ix == CCS_IDX_BFLAGS |-> ##2
      coef_negative[6] == $past(avs_writedata[13], 2)
      && coef_magnitude[118] == $past(avs_writedata[12], 2)) else $error("bridge 2nd flags");
   a_tflag_zero: assert property (acc_r && ix == CCS_IDX_TFLAGS |->
      avs_readdata[15:6] == 10'h000) else $error("temp flag spare bits set");
   a_gain_low: assert property (acc_w && ix == CCS_IDX_BGAIN |-> ##2
      coef_magnitude[32:17] == $past(avs_writedata[15:0], 2)) else $error("bridge gain low");
   a_tcg_low: assert property (acc_w && ix == CCS_IDX_TCG |-> ##2
      coef_magnitude[49:34] == $past(avs_writedata[15:0], 2)) else $error("gain tc low");
   a_tgain_flags: assert property (acc_w && ix == CCS_IDX_TFLAGS |-> ##2
      coef_negative[7] == $past(avs_writedata[1], 2)
      && coef_magnitude[135] == $past(avs_writedata[0], 2)) else $error("temp gain flags");
   a_twos_neg: assert property ($stable(coef_magnitude[33:17]) && $stable(coef_negative[1])
      |-> coef_twos[35:18] == (coef_negative[1] ? 18'h00000 - {1'b0, coef_magnitude[33:17]}
      : {1'b0, coef_magnitude[33:17]})) else $error("two's complement wrong");
   a_rd_high: assert property (avs_readdata[31:16] == 16'h0000)
      else $error("read data upper half set");
endmodule // ccs_store_asserts

/* File: ccs_store_tb_top.sv */
`timescale 1ns/1ps
module ccs_store_tb_top;
   import ccs_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'h3;
   logic avs_waitrequest, curve_shape_select, low_cal_temp_sign;
   logic [152:0] coef_magnitude;
   logic [8:0] coef_negative;
   logic [161:0] coef_twos;
   logic [15:0] low_cal_temp_reference;
   logic [15:0] fl [2] = '{16'h9e4d, 16'h61b2};
   logic [15:0] tf [2] = '{16'hffd9, 16'h0026};
   logic [3:0] cix [9] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #2.5 ref_clk = ~ref_clk;
   ccs_store i_dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .coef_magnitude, .coef_negative,
      .coef_twos, .curve_shape_select, .low_cal_temp_reference, .low_cal_temp_sign);
   task automatic final_report;
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Whole run is a few hundred cycles; this only cuts a hang
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cf(input int i, input logic [16:0] m, input logic s);
      logic [17:0] t;
      t = s ? 18'h00000 - {1'b0, m} : {1'b0, m};
      checks_done++;
      if (coef_magnitude[i*17+:17] !== m || coef_negative[i] !== s || coef_twos[i*18+:18] !== t)
      begin
         bad_count++;
         $display("BAD %0t coefficient %0d", $time, i);
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge; read data taken there
   task automatic bus(input logic w, input logic [3:0] ix, input logic [15:0] d,
      output logic [31:0] q);
      avs_address <= {ix, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      do
      begin
         @(posedge ref_clk);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // One idle edge so the next call never re-drives a strobe in the same step
      @(posedge ref_clk);
   endtask
   task automatic t_idle;
      logic [31:0] q;
      for (int i = 0; i < 9; i++)
         cf(i, 17'h00000, 1'b0);
      chk({16'h0000, low_cal_temp_reference}, 32'h0);
      chk({30'h0, curve_shape_select, low_cal_temp_sign}, 32'h0);
      for (int i = 0; i < 16; i++)
      begin
         bus(1'b0, i[3:0], 16'h0000, q);
         chk(q, 32'h0);
         if (i < 3)
         begin
            bus(1'b1, i[3:0], 16'hffff, q);
            bus(1'b0, i[3:0], 16'h0000, q);
            chk(q, 32'h0);
         end
      end
   endtask
   task automatic t_coef(input int p);
      logic [31:0] q;
      logic [15:0] lw, fg;
      bus(1'b1, 4'h3, fl[p], q);
      bus(1'b1, 4'h4, tf[p], q);
      for (int i = 0; i < 9; i++)
      begin
         lw = {i[3:0], 12'h5a3} ^ {16{p[0]}};
         bus(1'b1, cix[i], lw, q);
         bus(1'b0, cix[i], 16'h0000, q);
         chk(q, {16'h0000, lw});
      end
      bus(1'b0, 4'h4, 16'h0000, q);
      chk(q, {26'h0, tf[p][5:0]});
      bus(1'b0, 4'h3, 16'h0000, q);
      chk(q, {16'h0000, fl[p]});
      bus(1'b1, 4'hf, fl[p] ^ 16'h5a5a, q);
      @(negedge ref_clk);
      for (int i = 0; i < 9; i++)
      begin
         lw = {i[3:0], 12'h5a3} ^ {16{p[0]}};
         fg = (i < 7) ? fl[p] >> (2 * i) : tf[p] >> (2 * i - 14);
         cf(i, {fg[0], lw}, fg[1]);
      end
      chk({30'h0, curve_shape_select, low_cal_temp_sign}, {30'h0, fl[p][14], fl[p][15]});
      chk({16'h0000, low_cal_temp_reference}, {16'h0000, fl[p] ^ 16'h5a5a});
      @(posedge ref_clk);
   endtask
   task automatic t_range;
      logic [31:0] q;
      logic [15:0] v;
      for (int k = 0; k < 8; k++)
      begin
         v = 16'h7000 - 16'h1000 * k[15:0];
         bus(1'b1, 4'h5, v, q);
         bus(1'b1, 4'hc, v, q);
         bus(1'b0, 4'h5, 16'h0000, q);
         chk(q, {16'h0000, v});
         bus(1'b0, 4'hc, 16'h0000, q);
         chk(q, {16'h0000, v});
      end
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      t_idle();
      t_coef(0);
      t_coef(1);
      t_range();
      final_report();
   end
endmodule // ccs_store_tb_top
bind ccs_store ccs_store_asserts #(.NCOEF(NCOEF)) u_chk (.ref_clk, .rst_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .coef_magnitude, .coef_negative, .coef_twos, .curve_shape_select, .low_cal_temp_sign);
